/* lsc_defs.vh */
// constants for the segment lcd serial receive and decode block
`ifndef LSC_DEFS_VH
`define LSC_DEFS_VH
`define LSC_DEV_ADDR 8'h85
`define LSC_ADDR_BITS 8
`define LSC_GROUP_BITS 128
`define LSC_DISP_BITS 420
`define LSC_SEG_PINS 106
`define LSC_SHARED_PINS 8
`define LSC_PORT_MAX 4'h8
`define LSC_CT_MAX 3'h6
`define LSC_G1_DISP_LEN 108
`define LSC_G_DISP_LEN4 104
`define LSC_G3_DISP_LEN3 102
`define LSC_BASE2 108
`define LSC_BASE3_DUTY3 216
`define LSC_BASE3_DUTY4 212
`define LSC_BASE4_DUTY4 316
`define LSC_POS_PORT 108
`define LSC_POS_CT 112
`define LSC_POS_BIAS 115
`define LSC_POS_DUTY 116
`define LSC_POS_FRAME 117
`define LSC_POS_BLANK 118
`define LSC_POS_PSAVE 119
`define LSC_POS_DIR0 126
`define LSC_POS_DIR1 127
`define LSC_FRAME_DIV_FC1 192
`define LSC_FRAME_DIV_FC0 384
`define LSC_RST_PORT 4'h0
`define LSC_RST_CT 3'h0
`define LSC_RST_BIT 1'b0
`endif

/* lsc_sync2.v */
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module lsc_sync2 #(
    parameter W = 1
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second stage
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // lsc_sync2
`default_nettype wire

/* lsc_ctrl.v */
// segment lcd driver: serial receive, group decode, display store and phase drive
//
// Operation
// R1 - groups are 8-bit address then 128 bits; only matching address is kept
// R2 - one stored bit per segment/common crossing, 318 or 420 in total
// R3 - shift clock may idle low or high; both are accepted
// R4 - host sends all 384 bits in three-common with 217+ segments
// R5 - host sends 128 or 256 bits otherwise, always the first group
// R6 - host sends all 512 bits in four-common with 317+ segments
// R7 - host sends 128, 256 or 384 bits otherwise, always the first group
// R8 - port count n makes first n shared pins general outputs, rest segments
// R9 - port pin k follows display bit 3k-2 or 4k-3 by duty
// R10 - contrast code 0 to 6, seven steps of 0.05 supply each
// R11 - bias select 0 is one-third bias, 1 is one-half bias
// R12 - duty 0 four commons, 1 three commons with dual pin as segment
// R13 - frame rate select 1 divides oscillator by 192
// R14 - segment blank drives segment-off waveforms, commons keep running
// R15 - power save stops oscillator, outputs low, port pins keep working
// R16 - chip select brackets, shift clock times, data pin carries the bits
// R17 - display kill low forces all outputs low, pins segment, transfers go on
// R18 - bits shift on rising shift clock, latched when chip select ends
// R19 - direction bits at group tail pick the display section to load
// R20 - oscillator divided into three or four common phases per frame
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.vh"
module lsc_ctrl #(
    parameter FRAME_DIV_FC1 = `LSC_FRAME_DIV_FC1,
    parameter FRAME_DIV_FC0 = `LSC_FRAME_DIV_FC0
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire chip_sel_i,
    input wire shift_strobe_i,
    input wire serial_bit_in_i,
    input wire display_kill_n_i,
    output wire [3:0] com_o,
    output wire [`LSC_SEG_PINS-1:0] seg_o,
    output wire [7:0] port_mode_o,
    output wire [3:0] port_count_o,
    output wire [2:0] contrast_code_o,
    output wire bias_select_o,
    output wire duty_select_o,
    output wire frame_rate_select_o,
    output wire segment_blank_o,
    output wire power_save_o,
    output wire group_taken_o
);
    // phase lengths: one frame shared by three or four commons
    localparam integer PH3_FC1 = FRAME_DIV_FC1 / 3;
    localparam integer PH4_FC1 = FRAME_DIV_FC1 / 4;
    localparam integer PH3_FC0 = FRAME_DIV_FC0 / 3;
    localparam integer PH4_FC0 = FRAME_DIV_FC0 / 4;

    wire [3:0] pins_s;
    wire ce_s;
    wire clk_s;
    wire din_s;
    wire kill_n_s;

    reg clk_prev_q;
    reg ce_prev_q;
    reg [7:0] addr_q;
    reg addr_ok_q;
    reg [7:0] bitcnt_q;
    reg [`LSC_GROUP_BITS-1:0] sh_q;
    reg [`LSC_DISP_BITS-1:0] disp_q;
    reg [`LSC_DISP_BITS-1:0] disp_d;
    reg [3:0] port_q;
    reg [2:0] ct_q;
    reg bias_q;
    reg duty_q;
    reg frame_q;
    reg blank_q;
    reg psave_q;
    reg taken_q;
    reg [9:0] phcnt_q;
    reg [1:0] phase_q;
    reg [3:0] com_q;
    reg [`LSC_SEG_PINS-1:0] seg_q;
    reg [`LSC_SEG_PINS-1:0] seg_d;
    reg [7:0] pmode_q;
    reg [7:0] pmode_d;

    wire rise_clk;
    wire ce_fall;
    wire ce_rise;
    wire [1:0] dir;
    wire accept;
    wire [9:0] ph_last;
    wire [1:0] ph_top;
    wire [3:0] port_n;
    wire [2:0] ct_raw;
    integer i;
    integer s;
    integer base;
    integer len;

    // all four pins come from the host domain
    lsc_sync2 #(
        .W(4)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({display_kill_n_i, serial_bit_in_i, shift_strobe_i, chip_sel_i}),
        .sync_o(pins_s)
    );

    assign ce_s = pins_s[0];
    assign clk_s = pins_s[1];
    assign din_s = pins_s[2];
    assign kill_n_s = pins_s[3];

    // only rising edges count, so either idle level of the clock works
    assign rise_clk = clk_s & ~clk_prev_q; // R3
    assign ce_rise = ce_s & ~ce_prev_q; // R16
    assign ce_fall = ~ce_s & ce_prev_q; // R16
    assign dir = {sh_q[`LSC_POS_DIR0], sh_q[`LSC_POS_DIR1]};
    // a short or long burst is dropped rather than half stored
    assign accept = ce_fall & addr_ok_q & (bitcnt_q == 8'h80); // R1

    // edge history of the synchronised pins
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            clk_prev_q <= 1'b0;
            ce_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
            ce_prev_q <= ce_s;
        end
    end

    // address shifts with chip select low, data with it high
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q <= 8'h00;
            addr_ok_q <= 1'b0;
            bitcnt_q <= 8'h00;
            sh_q <= {`LSC_GROUP_BITS{1'b0}};
        end else begin
            if (ce_rise) begin
                addr_ok_q <= (addr_q == `LSC_DEV_ADDR); // R1
                bitcnt_q <= 8'h00;
            end else if (rise_clk && ce_s) begin
                sh_q <= {din_s, sh_q[`LSC_GROUP_BITS-1:1]}; // R18
                if (bitcnt_q != 8'hFF) begin
                    bitcnt_q <= bitcnt_q + 8'h01;
                end
            end else if (rise_clk && !ce_s) begin
                addr_q <= {din_s, addr_q[7:1]}; // R1
            end
        end
    end

    // place the group into its display section
    always @* begin
        disp_d = disp_q;
        base = 0;
        len = `LSC_G1_DISP_LEN;
        case (dir)
            2'b00: begin
                base = 0;
                len = `LSC_G1_DISP_LEN;
            end
            2'b01: begin
                base = `LSC_BASE2;
                len = duty_q ? `LSC_G1_DISP_LEN : `LSC_G_DISP_LEN4;
            end
            2'b10: begin
                base = duty_q ? `LSC_BASE3_DUTY3 : `LSC_BASE3_DUTY4;
                len = duty_q ? `LSC_G3_DISP_LEN3 : `LSC_G_DISP_LEN4;
            end
            default: begin
                // fourth group only exists in four-common drive
                base = `LSC_BASE4_DUTY4;
                len = duty_q ? 0 : `LSC_G_DISP_LEN4;
            end
        endcase
        for (i = 0; i < `LSC_G1_DISP_LEN; i = i + 1) begin
            if (i < len) begin
                disp_d[base + i] = sh_q[i]; // R19
            end
        end
    end

    // latch display and control storage when chip select ends
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            disp_q <= {`LSC_DISP_BITS{1'b0}};
            port_q <= `LSC_RST_PORT;
            ct_q <= `LSC_RST_CT;
            bias_q <= `LSC_RST_BIT;
            duty_q <= `LSC_RST_BIT;
            frame_q <= `LSC_RST_BIT;
            blank_q <= `LSC_RST_BIT;
            psave_q <= `LSC_RST_BIT;
            taken_q <= 1'b0;
        end else begin
            taken_q <= accept;
            if (accept) begin
                disp_q <= disp_d; // R2 R18
                if (dir == 2'b00) begin
                    port_q <= {sh_q[`LSC_POS_PORT], sh_q[`LSC_POS_PORT+1],
                               sh_q[`LSC_POS_PORT+2], sh_q[`LSC_POS_PORT+3]}; // R8
                    // saturate at storage so the output leaves straight from the flop
                    ct_q <= (ct_raw > `LSC_CT_MAX) ? `LSC_CT_MAX : ct_raw; // R10
                    bias_q <= sh_q[`LSC_POS_BIAS]; // R11
                    duty_q <= sh_q[`LSC_POS_DUTY]; // R12
                    frame_q <= sh_q[`LSC_POS_FRAME]; // R13
                    blank_q <= sh_q[`LSC_POS_BLANK]; // R14
                    psave_q <= sh_q[`LSC_POS_PSAVE]; // R15
                end
            end
        end
    end

    // phase timing: the system clock stands in for the rc oscillator
    assign ph_last = frame_q ? (duty_q ? PH3_FC1[9:0] - 10'd1 : PH4_FC1[9:0] - 10'd1)
                             : (duty_q ? PH3_FC0[9:0] - 10'd1 : PH4_FC0[9:0] - 10'd1); // R13
    assign ph_top = duty_q ? 2'd2 : 2'd3; // R20

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phcnt_q <= 10'h000;
            phase_q <= 2'd0;
        end else if (psave_q) begin
            // oscillator stopped: frame timing held at phase 0
            phcnt_q <= 10'h000; // R15
            phase_q <= 2'd0;
        end else if (phcnt_q >= ph_last) begin
            phcnt_q <= 10'h000;
            phase_q <= (phase_q >= ph_top) ? 2'd0 : phase_q + 2'd1; // R20
        end else begin
            phcnt_q <= phcnt_q + 10'h001;
        end
    end

    // values above the documented range saturate
    assign port_n = (port_q > `LSC_PORT_MAX) ? `LSC_PORT_MAX : port_q;
    assign ct_raw = {sh_q[`LSC_POS_CT+2], sh_q[`LSC_POS_CT+1], sh_q[`LSC_POS_CT]}; // R10

    // segment value per pin for the active common phase
    always @* begin
        seg_d = {`LSC_SEG_PINS{1'b0}};
        pmode_d = 8'h00;
        for (s = 0; s < `LSC_SEG_PINS; s = s + 1) begin
            if (duty_q) begin
                seg_d[s] = disp_q[3*s + phase_q]; // R20
            end else if (s < `LSC_SEG_PINS - 1) begin
                seg_d[s] = disp_q[4*s + phase_q]; // R12
            end
        end
        if (blank_q || psave_q || !kill_n_s) begin
            seg_d = {`LSC_SEG_PINS{1'b0}}; // R14 R15 R17
        end
        for (s = 0; s < `LSC_SHARED_PINS; s = s + 1) begin
            if (s < port_n && kill_n_s) begin
                pmode_d[s] = 1'b1; // R8
                seg_d[s] = duty_q ? disp_q[3*s] : disp_q[4*s]; // R9 R15
            end
        end
    end

    // registered drive outputs; blanking leaves commons running
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            com_q <= 4'h0;
            seg_q <= {`LSC_SEG_PINS{1'b0}};
            pmode_q <= 8'h00;
        end else begin
            seg_q <= seg_d;
            pmode_q <= pmode_d;
            if (psave_q || !kill_n_s) begin
                com_q <= 4'h0; // R15 R17
            end else begin
                com_q <= (4'h1 << phase_q) & (duty_q ? 4'h7 : 4'hF); // R12 R20
            end
        end
    end

    assign com_o = com_q;
    assign seg_o = seg_q;
    assign port_mode_o = pmode_q;
    assign port_count_o = port_q;
    assign contrast_code_o = ct_q;
    assign bias_select_o = bias_q;
    assign duty_select_o = duty_q;
    assign frame_rate_select_o = frame_q;
    assign segment_blank_o = blank_q;
    assign power_save_o = psave_q;
    assign group_taken_o = taken_q;
endmodule // lsc_ctrl
`default_nettype wire

/* lsc_host_model.sv */
// host model for the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
    output logic chip_sel_o,
    output logic shift_strobe_o,
    output logic serial_bit_o
);
    initial begin
        chip_sel_o = 1'b0;
        shift_strobe_o = 1'b0;
        serial_bit_o = 1'b0;
    end
    // rising strobe mid cell takes the bit, strobe left high at cell end
    task automatic put_bit(input logic b);
        serial_bit_o = b;
        shift_strobe_o = 1'b0;
        #62.5;
        shift_strobe_o = 1'b1;
        #62.5;
    endtask
    // address lsb first with select low, then data under select, any group by its tail bits
    task automatic send(input logic [7:0] a, input logic [127:0] v, input int n,
        input logic hi);
        // quarter-ns skew keeps every pin change off a system clock edge
        #0.25;
        for (int i = 0; i < 8; i++) put_bit(a[i]);
        shift_strobe_o = hi;
        #62.5;
        chip_sel_o = 1'b1;
        #62.5;
        for (int i = 0; i < n; i++) put_bit(v[i]);
        shift_strobe_o = hi;
        #62.5;
        chip_sel_o = 1'b0;
        // released line must not keep its last value
        serial_bit_o = ~serial_bit_o;
    endtask
endmodule // lsc_host_model
`default_nettype wire

/* lsc_ctrl_checker.sv */
// port assertions for the lcd serial decode block
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_checker (
    input wire clk_sys_i,
    input wire rst_i,
    input wire chip_sel_i,
    input wire display_kill_n_i,
    input wire [3:0] com_o,
    input wire [105:0] seg_o,
    input wire [7:0] port_mode_o,
    input wire [3:0] port_count_o,
    input wire [2:0] contrast_code_o,
    input wire duty_select_o,
    input wire segment_blank_o,
    input wire power_save_o,
    input wire group_taken_o
);
    // expected pin modes; counts above eight saturate
    wire [7:0] therm = (port_count_o >= 4'h8) ? 8'hFF : ((8'h01 << port_count_o) - 8'h01);
    wire seg_quiet = (seg_o[105:8] == 98'h0) && ((seg_o[7:0] & ~port_mode_o) == 8'h00);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_contrast_in_range: assert property (contrast_code_o <= 3'h6)
        else $error("contrast code above six");
    a_port_thermo: assert property ((port_mode_o != 8'h00 && $stable(port_count_o)) |-> port_mode_o == therm)
        else $error("port modes disagree with count");
    a_com_one_hot: assert property ($onehot0(com_o))
        else $error("more than one common active");
    a_duty_three: assert property (duty_select_o && $past(duty_select_o) |-> !com_o[3])
        else $error("fourth common active in three-common");
    a_save_quiet: assert property (power_save_o && $past(power_save_o) |-> com_o == 4'h0 && seg_quiet)
        else $error("outputs run in power save");
    a_blank_segs: assert property (segment_blank_o && $past(segment_blank_o) |-> seg_quiet)
        else $error("segment on while blanked");
    a_kill_quiet: assert property (!display_kill_n_i [*6] |-> com_o == 4'h0 && seg_o == 106'h0 && port_mode_o == 8'h00)
        else $error("outputs active under kill");
    a_taken_pulse: assert property (group_taken_o |-> !chip_sel_i && !$past(chip_sel_i) ##1 !group_taken_o)
        else $error("bad group taken pulse");
endmodule // lsc_ctrl_checker
bind lsc_ctrl lsc_ctrl_checker chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .chip_sel_i(chip_sel_i),
    .display_kill_n_i(display_kill_n_i), .com_o(com_o), .seg_o(seg_o), .port_mode_o(port_mode_o),
    .port_count_o(port_count_o), .contrast_code_o(contrast_code_o), .duty_select_o(duty_select_o),
    .segment_blank_o(segment_blank_o), .power_save_o(power_save_o), .group_taken_o(group_taken_o));
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the lcd serial decode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i, rst_i, kill_n;
    wire cs, stb, sdi, bias, duty, fr, blank, ps, taken;
    wire [3:0] com, pc;
    wire [105:0] seg;
    wire [7:0] pm;
    wire [2:0] ct;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    lsc_host_model host_u (.chip_sel_o(cs), .shift_strobe_o(stb), .serial_bit_o(sdi));
    // short frame divisors keep a frame to 12 or 24 cycles
    lsc_ctrl #(.FRAME_DIV_FC1(12), .FRAME_DIV_FC0(24)) dut_u (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .chip_sel_i(cs), .shift_strobe_i(stb), .serial_bit_in_i(sdi),
        .display_kill_n_i(kill_n), .com_o(com), .seg_o(seg), .port_mode_o(pm),
        .port_count_o(pc), .contrast_code_o(ct), .bias_select_o(bias), .duty_select_o(duty),
        .frame_rate_select_o(fr), .segment_blank_o(blank), .power_save_o(ps),
        .group_taken_o(taken));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // group one: display bits 0, 4, 6 set, then the control fields
    function automatic logic [127:0] mk(input logic [3:0] p, input logic [2:0] c,
        input logic [4:0] f);
        logic [127:0] v;
        v = 128'h51;
        for (int i = 0; i < 4; i++) v[108 + i] = p[3 - i];
        v[114:112] = c;
        v[119:115] = f;
        return v;
    endfunction
    // one group, then look for the accept pulse in a bounded window
    task automatic xfer(input logic [7:0] a, input logic [127:0] v, input int n,
        input logic hi, input logic e);
        logic seen;
        seen = 1'b0;
        host_u.send(a, v, n, hi);
        repeat (12) begin
            @(posedge clk_sys_i);
            #1;
            if (taken === 1'b1) seen = 1'b1;
        end
        chk(32'(seen), 32'(e));
    endtask
    // union of active commons over 48 cycles, two 24-cycle or four 12-cycle frames
    task automatic coms(input logic [3:0] e);
        logic [3:0] acc;
        acc = 4'h0;
        repeat (48) begin
            @(posedge clk_sys_i);
            #1;
            acc = acc | com;
        end
        chk(32'(acc), 32'(e));
    endtask
    task automatic t_three();
        xfer(8'h85, mk(4'h3, 3'h5, 5'b00111), 128, 1'b0, 1'b1);
        chk(32'({pc, pm, ct}), 32'({4'h3, 8'h07, 3'h5}));
        chk(32'({bias, duty, fr, blank, ps}), 32'h1C);
        chk(32'(seg[2:0]), 32'h5);
        coms(4'h7);
    endtask
    task automatic t_refuse();
        xfer(8'h84, mk(4'h8, 3'h0, 5'b0), 128, 1'b1, 1'b0);
        xfer(8'h85, mk(4'h8, 3'h0, 5'b0), 127, 1'b1, 1'b0);
        chk(32'(pc), 32'h3);
    endtask
    task automatic t_four();
        xfer(8'h85, mk(4'h8, 3'h7, 5'b0), 128, 1'b1, 1'b1);
        chk(32'({pc, pm, ct, duty}), 32'({4'h8, 8'hFF, 3'h6, 1'b0}));
        chk(32'(seg[2:0]), 32'h3);
        coms(4'hF);
    endtask
    // groups two to four in four-common: ones across each display section
    task automatic t_groups();
        for (int g = 1; g < 4; g++) begin
            xfer(8'h85, {g[0], g[1], 22'h0, {104{1'b1}}}, 128, 1'b1, 1'b1);
            do begin
                @(posedge clk_sys_i);
                #1;
            end while (com !== 4'h1);
            chk(32'(seg[26 * g + 1 +: 26]), 32'h3FFFFFF);
            chk(32'(|(seg[104:27] >> (26 * g))), 32'h0);
        end
    endtask
    task automatic t_kill();
        kill_n = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        #1 chk(32'({|seg, com, pm}), 32'h0);
        xfer(8'h85, mk(4'h2, 3'h0, 5'b01000), 128, 1'b0, 1'b1);
        kill_n = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        #1 chk(32'({blank, pm, |seg[105:2], seg[1:0]}), 32'h81B);
        coms(4'hF);
    endtask
    task automatic t_save();
        xfer(8'h85, mk(4'h1, 3'h0, 5'b10000), 128, 1'b0, 1'b1);
        repeat (4) @(posedge clk_sys_i);
        #1 chk(32'({ps, com, |seg[105:1], seg[0]}), 32'h41);
    endtask
    initial begin
        kill_n = 1'b1;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        chk(32'({pc, pm, ct, bias, duty, fr, blank, ps, taken}), 32'h0);
        t_three();
        t_refuse();
        t_four();
        t_groups();
        t_kill();
        t_save();
        print_verdict();
    end
    // the run needs about 20000 cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end
endmodule // tb_top
`default_nettype wire
